// ===== core/eepi2c_pkg.sv
// Shared constants of the serial EEPROM two-wire slave front end
package eepi2c_pkg;

  // Fixed four-bit device type code at the top of the address byte
  localparam logic [3:0] EEPI2C_TYPE_CODE = 4'hA;
  // Direction bit values
  localparam logic EEPI2C_DIR_READ = 1'b1;
  localparam logic EEPI2C_DIR_WRITE = 1'b0;
  // Memory address width of the larger variant, page size in bytes
  localparam int EEPI2C_ADDR_W = 15;
  localparam int EEPI2C_PAGE_BYTES = 64;
  // Bit slots of one byte, count of the last data bit
  localparam logic [3:0] EEPI2C_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] EEPI2C_LAST_TX_BIT = 4'h7;
  // Byte slot index after the address byte: high, low, then data
  localparam logic [1:0] EEPI2C_SLOT_ADDR_HI = 2'h0;
  localparam logic [1:0] EEPI2C_SLOT_ADDR_LO = 2'h1;
  localparam logic [1:0] EEPI2C_SLOT_DATA = 2'h2;
  // Timing: system clock period and longest programming cycle
  localparam int EEPI2C_CLK_PERIOD_NS = 5;
  localparam int EEPI2C_TWC_MAX_NS = 10000000;
  // Longest time rounds down to whole cycles
  localparam int EEPI2C_TWC_CYCLES = EEPI2C_TWC_MAX_NS / EEPI2C_CLK_PERIOD_NS;

endpackage

// ===== core/eepi2c_page_buf.sv
// Page data latches: small memory with registered read data
`timescale 1ns/1ps
module eepi2c_page_buf
  import eepi2c_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int DEPTH = EEPI2C_PAGE_BYTES
)
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data_ff
);

  // Storage array, no reset needed for data
  logic [DATA_W-1:0] mem_ff [DEPTH];

  // Refuse shapes the address decode cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_chk_depth
    $error("page buffer depth must be a power of two");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write port
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  // Read port, data comes out of a register
  always_ff @(posedge clk)
  begin
    rd_data_ff <= mem_ff[rd_addr];
  end

endmodule

// ===== core/eepi2c_slave.sv
// Two-wire slave front end of a serial byte-addressed EEPROM
`timescale 1ns/1ps
module eepi2c_slave
  import eepi2c_pkg::*;
#(
  parameter int ADDR_W = EEPI2C_ADDR_W,
  parameter int PAGE_BYTES = EEPI2C_PAGE_BYTES,
  parameter int TWC_CYCLES = EEPI2C_TWC_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_ff,
  output logic sda_oe_n_ff,
  input wire logic [2:0] chip_sel,
  input wire logic write_protect,
  output logic [ADDR_W-1:0] mem_rd_addr_ff,
  input wire logic [7:0] mem_rd_data,
  output logic mem_wr_en_ff,
  output logic [ADDR_W-1:0] mem_wr_addr_ff,
  output logic [7:0] mem_wr_data,
  output logic prog_busy_ff
);

  localparam int PW = $clog2(PAGE_BYTES);

  // Refuse values the logic cannot serve
  if (ADDR_W < 9 || ADDR_W > 16 || PAGE_BYTES > (1 << ADDR_W) || TWC_CYCLES < PAGE_BYTES + 2)
  begin : g_chk_par
    $error("unsupported address width, page size or cycle count");
  end

  // Protocol states
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_DEVADR = 7'b0000010,
    ST_ACK = 7'b0000100,
    ST_RX = 7'b0001000,
    ST_TX = 7'b0010000,
    ST_MACK = 7'b0100000,
    ST_PROG = 7'b1000000
  } eepi2c_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers
  logic [1:0] rst_sync_ff; // Reset release pipe
  logic rst_n; // Synchronised power-up reset, low active
  logic scl_meta_ff, scl_ff, scl_d_ff; // Clock pin sync and history
  logic sda_meta_ff, sda_ff, sda_d_ff; // Data pin sync and history
  logic [2:0] cs_meta_ff, cs_ff; // Select pins
  logic wp_meta_ff, wp_ff; // Write protect pin

  // Release reset through two flops
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // Two flops per pin, a third stage on clock and data only for edge finding
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {scl_meta_ff, scl_ff, scl_d_ff} <= 3'h7;
      {sda_meta_ff, sda_ff, sda_d_ff} <= 3'h7;
      cs_meta_ff <= 3'h0;
      cs_ff <= 3'h0;
      wp_meta_ff <= 1'b0;
      wp_ff <= 1'b0;
    end
    else
    begin
      {scl_meta_ff, scl_ff, scl_d_ff} <= {scl_in, scl_meta_ff, scl_ff};
      {sda_meta_ff, sda_ff, sda_d_ff} <= {sda_in, sda_meta_ff, sda_ff};
      cs_meta_ff <= chip_sel;
      cs_ff <= cs_meta_ff;
      wp_meta_ff <= write_protect;
      wp_ff <= wp_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus events
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_ff & ~scl_d_ff;
  assign scl_fall = ~scl_ff & scl_d_ff;
  // Data edges while the clock stays high
  assign start_det = scl_ff & scl_d_ff & sda_d_ff & ~sda_ff;
  assign stop_det = scl_ff & scl_d_ff & ~sda_d_ff & sda_ff;

  eepi2c_state_e state_ff; // Protocol state
  logic [3:0] bit_cnt_ff; // Bits of the current byte
  logic [7:0] shift_ff; // Receive and transmit shifter
  logic dir_ff; // Direction of current transfer
  logic [1:0] slot_ff; // Byte slot within a write transfer
  logic [7:0] addr_hi_ff; // Held high address byte
  logic mack_ff; // Master acknowledge seen
  logic stop_ok_ff; // In the clock period after an acknowledge
  logic wr_pend_ff; // Data bytes taken since the address byte
  logic [ADDR_W-1:0] addr_ff; // Internal address counter
  logic [PW:0] page_cnt_ff; // Buffered byte count
  logic [ADDR_W-1:0] base_ff; // First buffered location
  logic [PW:0] prog_idx_ff; // Next byte to hand to the array
  logic [31:0] twc_cnt_ff; // Programming cycle timer
  logic [PW-1:0] buf_rd_addr;

  // Events decoded from state
  logic byte_in_done, dev_match, data_rx, addr_lo_rx, tx_load, tx_done, prog_go, prog_end;
  assign byte_in_done = scl_fall && bit_cnt_ff == EEPI2C_BITS_PER_BYTE
                        && (state_ff == ST_DEVADR || state_ff == ST_RX);
  // Type code and select bits must both match
  assign dev_match = shift_ff[7:4] == EEPI2C_TYPE_CODE && shift_ff[3:1] == cs_ff;
  assign addr_lo_rx = byte_in_done && state_ff == ST_RX && slot_ff == EEPI2C_SLOT_ADDR_LO;
  assign data_rx = byte_in_done && state_ff == ST_RX && slot_ff == EEPI2C_SLOT_DATA;
  // Load a byte after our acknowledge of a read, or after a master acknowledge
  assign tx_load = scl_fall && ((state_ff == ST_ACK && dir_ff == EEPI2C_DIR_READ)
                   || (state_ff == ST_MACK && mack_ff));
  assign tx_done = scl_fall && state_ff == ST_TX && bit_cnt_ff == EEPI2C_LAST_TX_BIT;
  // Programming needs data, a stop in the tenth clock, and no protection
  assign prog_go = stop_det && state_ff != ST_PROG && wr_pend_ff && stop_ok_ff && !wp_ff;
  assign prog_end = twc_cnt_ff == 32'(TWC_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state, shifter and data line drive
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) // Every command ignored while reset holds
    begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      dir_ff <= EEPI2C_DIR_WRITE;
      slot_ff <= EEPI2C_SLOT_ADDR_HI;
      addr_hi_ff <= 8'h00;
      mack_ff <= 1'b0;
      stop_ok_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
    end
    else if (state_ff == ST_PROG)
    begin
      // All bus inputs ignored, so polls get no acknowledge
      sda_oe_n_ff <= 1'b1;
      wr_pend_ff <= 1'b0;
      if (prog_end)
        state_ff <= ST_IDLE;
    end
    else if (stop_det)
    begin
      // Back to standby, or into the timed cycle
      state_ff <= prog_go ? ST_PROG : ST_IDLE;
      sda_oe_n_ff <= 1'b1;
      wr_pend_ff <= 1'b0;
    end
    else if (start_det)
    begin
      // Start or repeated start, no stop needed before a read
      state_ff <= ST_DEVADR;
      bit_cnt_ff <= 4'h0;
      slot_ff <= EEPI2C_SLOT_ADDR_HI;
      sda_oe_n_ff <= 1'b1;
      stop_ok_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          sda_oe_n_ff <= 1'b1;
        end
        ST_DEVADR, ST_RX:
        begin
          if (scl_rise)
          begin
            // Shift in on the rising edge
            shift_ff <= {shift_ff[6:0], sda_ff};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          else if (byte_in_done)
          begin
            if (state_ff == ST_DEVADR && !dev_match)
              state_ff <= ST_IDLE; // Not ours: no acknowledge
            else
            begin
              state_ff <= ST_ACK;
              sda_oe_n_ff <= 1'b0; // Acknowledge every byte taken
            end
            if (state_ff == ST_DEVADR)
              dir_ff <= shift_ff[0];
            else if (slot_ff == EEPI2C_SLOT_ADDR_HI)
              addr_hi_ff <= shift_ff; // High byte first
            if (state_ff == ST_RX && slot_ff != EEPI2C_SLOT_DATA)
              slot_ff <= slot_ff + 2'h1;
            if (data_rx)
              wr_pend_ff <= 1'b1;
          end
          if (scl_fall)
            stop_ok_ff <= 1'b0; // Tenth clock window closes at its fall
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_ff <= 4'h0;
            if (dir_ff == EEPI2C_DIR_READ)
            begin
              state_ff <= ST_TX;
              shift_ff <= mem_rd_data; // Byte at the counter
              sda_oe_n_ff <= mem_rd_data[7]; // MSB first, release for one
            end
            else
            begin
              state_ff <= ST_RX;
              sda_oe_n_ff <= 1'b1;
              stop_ok_ff <= 1'b1; // Stop may now start programming
            end
          end
        end
        ST_TX:
        begin
          if (tx_done)
          begin
            state_ff <= ST_MACK;
            sda_oe_n_ff <= 1'b1; // Release for the master acknowledge
          end
          else if (scl_fall)
          begin
            // Next bit on the falling edge
            shift_ff <= {shift_ff[6:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            sda_oe_n_ff <= shift_ff[6];
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
            mack_ff <= ~sda_ff;
          else if (tx_load)
          begin
            state_ff <= ST_TX; // Master wants more
            bit_cnt_ff <= 4'h0;
            shift_ff <= mem_rd_data;
            sda_oe_n_ff <= mem_rd_data[7];
          end
          else if (scl_fall)
            state_ff <= ST_IDLE; // No acknowledge: standby
        end
        default:
        begin
          state_ff <= ST_IDLE;
          sda_oe_n_ff <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address counter and read address to the array
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_ff <= '0;
      mem_rd_addr_ff <= '0;
    end
    else
    begin
      if (addr_lo_rx)
        // Load from both bytes; unused top bits dropped
        addr_ff <= ADDR_W'({addr_hi_ff, shift_ff});
      else if (data_rx || tx_done)
        // Last location plus one, wraps to zero
        addr_ff <= addr_ff + 1'b1;
      mem_rd_addr_ff <= addr_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page fill bookkeeping
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      page_cnt_ff <= '0;
      base_ff <= '0;
    end
    else if (start_det && state_ff != ST_PROG)
      page_cnt_ff <= '0;
    else if (data_rx)
    begin
      if (page_cnt_ff == '0)
        base_ff <= addr_ff;
      if (page_cnt_ff != (PW+1)'(PAGE_BYTES))
        page_cnt_ff <= page_cnt_ff + 1'b1; // Up to one page
    end
  end

  // Latch each data byte at its place in the page
  eepi2c_page_buf #(
    .DATA_W(8),
    .DEPTH(PAGE_BYTES)
  ) u_page_buf (
    .clk(sys_clk),
    .wr_en(data_rx),
    .wr_addr(addr_ff[PW-1:0]),
    .wr_data(shift_ff),
    .rd_addr(buf_rd_addr),
    .rd_data_ff(mem_wr_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Programming cycle: hand buffered bytes to the array, then time out
  logic [ADDR_W-1:0] prog_addr;
  logic prog_rd;
  assign prog_addr = base_ff + ADDR_W'(prog_idx_ff);
  assign buf_rd_addr = prog_addr[PW-1:0];
  assign prog_rd = state_ff == ST_PROG && prog_idx_ff != page_cnt_ff;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_idx_ff <= '0;
      twc_cnt_ff <= 32'h0;
      mem_wr_en_ff <= 1'b0;
      mem_wr_addr_ff <= '0;
      prog_busy_ff <= 1'b0;
    end
    else
    begin
      // Write strobe follows the buffer read by one cycle
      mem_wr_en_ff <= prog_rd;
      mem_wr_addr_ff <= prog_addr;
      if (state_ff != ST_PROG)
      begin
        prog_idx_ff <= '0;
        twc_cnt_ff <= 32'h0;
      end
      else
      begin
        if (prog_rd)
          prog_idx_ff <= prog_idx_ff + 1'b1;
        if (!prog_end)
          twc_cnt_ff <= twc_cnt_ff + 32'h1; // Bounded cycle length
      end
      prog_busy_ff <= prog_go || (state_ff == ST_PROG && !prog_end);
    end
  end

  // Data line only ever pulled low
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      sda_out_ff <= 1'b0;
    else
      sda_out_ff <= 1'b0;
  end

endmodule

// ===== testbench/eepi2c_slave_assertions.sv
// Checker of the EEPROM two-wire slave port behaviour
`timescale 1ns/1ps
module eepi2c_slave_checker
  import eepi2c_pkg::*;
#(
  parameter int ADDR_W = EEPI2C_ADDR_W,
  parameter int TWC_CYCLES = EEPI2C_TWC_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out_ff,
  input wire logic sda_oe_n_ff,
  input wire logic write_protect,
  input wire logic mem_wr_en_ff,
  input wire logic [ADDR_W-1:0] mem_wr_addr_ff,
  input wire logic prog_busy_ff
);
  // Cycles spent in the current programming cycle
  int busy_cnt_ff;
  // Counts while busy, clears when idle
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      busy_cnt_ff <= 0;
    else
      busy_cnt_ff <= prog_busy_ff ? busy_cnt_ff + 1 : 0;
  end
  ////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_reset_idle:
    assert property (disable iff (1'b0) !rstn ##1 !rstn |-> sda_oe_n_ff && !prog_busy_ff && !mem_wr_en_ff)
    else $error("bus active during reset");
  a_never_high: assert property (sda_out_ff == 1'b0) else $error("data driven high");
  a_drive_clk_low: assert property ($fell(sda_oe_n_ff) |-> !scl_in) else $error("drive while clock high");
  a_release_clk_low:
    assert property ($rose(sda_oe_n_ff) |-> !scl_in) else $error("release while clock high");
  a_stable_clk_high:
    assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n_ff)) else $error("data moved while clock high");
  a_busy_no_ack: assert property (prog_busy_ff |-> sda_oe_n_ff) else $error("answer while programming");
  a_prog_on_stop:
    assert property ($rose(prog_busy_ff) |-> scl_in && sda_in && !write_protect) else $error("bad program start");
  a_prog_writes:
    assert property ($rose(prog_busy_ff) |-> ##[1:80] mem_wr_en_ff) else $error("no array write");
  a_wr_in_prog: assert property (mem_wr_en_ff |-> prog_busy_ff) else $error("write outside programming");
  a_wr_addr_step:
    assert property (mem_wr_en_ff && $past(mem_wr_en_ff) |-> mem_wr_addr_ff == ADDR_W'($past(mem_wr_addr_ff) + 1'b1))
    else $error("write address skipped");
  a_prog_bounded: assert property (busy_cnt_ff <= TWC_CYCLES) else $error("programming too long");
endmodule
bind eepi2c_slave eepi2c_slave_checker #(.ADDR_W(ADDR_W), .TWC_CYCLES(TWC_CYCLES)) u_chk (.sys_clk(sys_clk),
  .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out_ff(sda_out_ff), .sda_oe_n_ff(sda_oe_n_ff),
  .write_protect(write_protect), .mem_wr_en_ff(mem_wr_en_ff), .mem_wr_addr_ff(mem_wr_addr_ff),
  .prog_busy_ff(prog_busy_ff));

// ===== testbench/eepi2c_master_model.sv
// Two-wire bus master model that drives the serial clock
`timescale 1ns/1ps
module eepi2c_master_model
(
  input wire logic sys_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  // Quarter of the 160 ns link period in system cycles
  localparam int QTR = 8;
  // Bus idles with both lines high
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Wait some system clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One bit: data set while clock low, read mid-high
  task automatic bit_slot(input logic b, output logic r);
    tick(QTR);
    sda_drv <= b;
    tick(QTR);
    scl <= 1'b1;
    tick(QTR);
    r = sda_wire;
    tick(QTR);
    scl <= 1'b0;
  endtask
  // Start: data falls while clock high
  task automatic start_cond();
    tick(QTR);
    sda_drv <= 1'b1;
    tick(QTR);
    scl <= 1'b1;
    tick(QTR);
    sda_drv <= 1'b0;
    tick(QTR);
    scl <= 1'b0;
  endtask
  // Stop: data rises while clock high, clock then stands still
  task automatic stop_cond();
    tick(QTR);
    sda_drv <= 1'b0;
    tick(QTR);
    scl <= 1'b1;
    tick(QTR);
    sda_drv <= 1'b1;
    tick(4 * QTR);
  endtask
  // Byte slot, MSB first, then the acknowledge clock
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(d[i], r);
      q[i] = r;
    end
    bit_slot(ack_in, ack_out);
  endtask
endmodule

// ===== testbench/eepi2c_slave_tb_top.sv
// Self-checking bench of the EEPROM two-wire slave front end
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module eepi2c_slave_tb_top
  import eepi2c_pkg::*;
;
  // Short programming time and our select pin levels
  localparam int TWC = 2000;
  localparam logic [2:0] SEL = 3'h5;
  logic sys_clk, rstn, scl, sda_m, sda_wire, wp, oe_n, sda_out, wr_en, busy, a;
  logic [14:0] rd_addr, wr_addr;
  logic [7:0] rd_data, wr_data, q;
  logic [7:0] mem [0:32767];
  int num_errors, checked, wr_count, base;
  // Open-drain wire with pull-up
  assign sda_wire = sda_m & (oe_n | sda_out);
  eepi2c_slave #(.TWC_CYCLES(TWC)) dut (.sys_clk(sys_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_wire),
    .sda_out_ff(sda_out), .sda_oe_n_ff(oe_n), .chip_sel(SEL), .write_protect(wp), .mem_rd_addr_ff(rd_addr),
    .mem_rd_data(rd_data), .mem_wr_en_ff(wr_en), .mem_wr_addr_ff(wr_addr), .mem_wr_data(wr_data),
    .prog_busy_ff(busy));
  eepi2c_master_model m (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_m));
  // Array model: registered read, write on pulse
  always @(posedge sys_clk)
  begin
    rd_data <= mem[rd_addr];
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
      wr_count++;
    end
  end
  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  // Print counts and verdict, then end
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Address byte for our device
  function automatic logic [7:0] dev(input logic dir);
    return {EEPI2C_TYPE_CODE, SEL, dir};
  endfunction
  // Send a byte and compare the acknowledge bit
  task automatic put(input logic [7:0] d, input logic exp_nack);
    m.xfer(d, 1'b1, q, a);
    `CHK(a, exp_nack)
  endtask
  // Fetch a byte, answer it, compare the data
  task automatic get(input logic [7:0] exp, input logic nack);
    m.xfer(8'hFF, nack, q, a);
    `CHK(q, exp)
  endtask
  // Start, write address byte, two memory address bytes
  task automatic set_addr(input logic [15:0] ad);
    m.start_cond();
    put(dev(EEPI2C_DIR_WRITE), 1'b0);
    put(ad[15:8], 1'b0);
    put(ad[7:0], 1'b0);
  endtask
  // Poll until answered; the first try must be refused
  task automatic poll();
    int n;
    n = 0;
    do
    begin
      m.start_cond();
      m.xfer(dev(EEPI2C_DIR_WRITE), 1'b1, q, a);
      n++;
    end
    while (a !== 1'b0 && n < 30);
    m.stop_cond();
    `CHK(n > 1, 1'b1)
    `CHK(a, 1'b0)
    if (n >= 30)
      conclude();
  endtask
  ////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    wp = 1'b0;
    num_errors = 0;
    checked = 0;
    wr_count = 0;
    mem[0] = 8'h3C;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    // Byte write at the last location
    set_addr(16'h7FFF);
    put(8'hA5, 1'b0);
    m.stop_cond();
    poll();
    `CHK(mem[15'h7FFF], 8'hA5)
    // Current read from the wrapped counter
    m.start_cond();
    put(dev(EEPI2C_DIR_READ), 1'b0);
    get(8'h3C, 1'b1);
    m.stop_cond();
    $display("test write_then_read done");
    // Only our select code and type code draw an answer
    for (int s = 0; s < 8; s++)
    begin
      m.start_cond();
      put({EEPI2C_TYPE_CODE, 3'(s), EEPI2C_DIR_WRITE}, 3'(s) != SEL);
      m.stop_cond();
    end
    m.start_cond();
    put({4'hB, SEL, EEPI2C_DIR_WRITE}, 1'b1);
    m.stop_cond();
    $display("test select done");
    // Full page, top address bit ignored, then sequential read
    base = wr_count;
    set_addr(16'h8100);
    for (int i = 0; i < EEPI2C_PAGE_BYTES; i++)
      put(8'(i) ^ 8'h5A, 1'b0);
    m.stop_cond();
    poll();
    `CHK(wr_count - base, EEPI2C_PAGE_BYTES)
    set_addr(16'h0100);
    m.start_cond();
    put(dev(EEPI2C_DIR_READ), 1'b0);
    for (int i = 0; i < EEPI2C_PAGE_BYTES; i++)
      get(8'(i) ^ 8'h5A, i == EEPI2C_PAGE_BYTES - 1);
    m.stop_cond();
    $display("test page done");
    // Protected write: no programming, ready at once
    wp <= 1'b1;
    base = wr_count;
    set_addr(16'h0200);
    put(8'h77, 1'b0);
    m.stop_cond();
    `CHK(busy, 1'b0)
    m.start_cond();
    put(dev(EEPI2C_DIR_WRITE), 1'b0);
    m.stop_cond();
    `CHK(wr_count, base)
    $display("test protect done");
    // Stop one clock late after the acknowledge: no programming
    wp <= 1'b0;
    set_addr(16'h0300);
    put(8'h66, 1'b0);
    m.bit_slot(1'b1, a);
    m.stop_cond();
    m.start_cond();
    put(dev(EEPI2C_DIR_WRITE), 1'b0);
    m.stop_cond();
    `CHK(wr_count, base)
    $display("test late_stop done");
    // Reset in mid-run: counter back to zero, device answers again
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    m.start_cond();
    put(dev(EEPI2C_DIR_READ), 1'b0);
    get(8'h3C, 1'b1);
    m.stop_cond();
    $display("test reset done");
    conclude();
  end
endmodule
